// ---- hdl/fes_pkg.sv ----
/*
 Shared constants and types for the fetch/execute sequencer.
 Assumes one clock, one active-low asynchronous reset and a
 program memory that answers within three phase periods of the address.
*/
// What this block does
// - Divide clock by four into four phases
// - Instruction cycle is phases one to four
// - Fetch next while executing previous instruction
// - Program counter changes take two cycles
// - Program counter increments in phase one
// - Instruction register loads in phase one
// - Decode and execute across phases two-four
// - Operand read phase two, write phase four
// - Branch flushes prefetched word, refetches target
package fes_pkg;
    localparam int unsigned PC_W = 13;
    localparam int unsigned IR_W = 14;
    localparam int unsigned DW   = 8;
    localparam int unsigned FA_W = 8;

    localparam logic [7:0] IND_PORT_OFS = 8'h80;
    localparam logic [7:0] PC_LOW_OFS   = 8'h82;
    localparam logic [7:0] STAT_OFS     = 8'h83;
    localparam logic [7:0] IND_PTR_OFS  = 8'h84;
    localparam logic [7:0] PC_HI_OFS    = 8'h8A;
    localparam logic [7:0] CTRL_OFS   = 8'hF0;
    localparam logic [7:0] STATE_OFS  = 8'hF1;

    localparam logic [7:0] PC_LOW_RST  = 8'h00;
    localparam logic [7:0] STAT_RST    = 8'h18;
    localparam logic [7:0] IND_PTR_RST = 8'h00;
    localparam logic [4:0] PC_HI_RST   = 5'h00;
    localparam logic [7:0] MEM_RST    = 8'h00;

    localparam int unsigned STAT_C   = 0;
    localparam int unsigned STAT_Z   = 2;
    localparam int unsigned STAT_RP0 = 5;
    localparam int unsigned CTRL_RUN = 0;

    localparam logic [1:0] OP_FILE = 2'h0;
    localparam logic [1:0] OP_JUMP = 2'h2;
    localparam logic [1:0] OP_LIT  = 2'h3;
    localparam logic [3:0] FOP_MOVWF = 4'h1;
    localparam logic [3:0] FOP_MOVF  = 4'h2;
    localparam logic [3:0] FOP_ADDWF = 4'h3;
    localparam logic [3:0] FOP_CLRF  = 4'h4;
    localparam logic [13:0] IR_NOP   = 14'h0000;

    typedef enum logic [1:0] {
        PH_ONE   = 2'b00,
        PH_TWO   = 2'b01,
        PH_THREE = 2'b11,
        PH_FOUR  = 2'b10
    } fes_phase_type;

    typedef enum logic [2:0] {
        SP_NONE, SP_IND_PORT, SP_PC_LOW, SP_STAT, SP_IND_PTR, SP_PC_HI
    } fes_spec_type;

    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fes_dm_port_type;
endpackage : fes_pkg

// ---- hdl/fes_dmem.sv ----
/*
 Data memory with two ports, registered read data on each.
 Assumes callers never need a write to be visible in the same cycle.
*/
`timescale 1ns/1ns
module fes_dmem
    import fes_pkg::*;
#(
    parameter int unsigned DEPTH = 256
) (
    input  wire logic            clk_i,
    input  wire logic            resetn_i,
    input  wire logic            ce_i,
    input  wire fes_dm_port_type a_i,
    input  wire fes_dm_port_type b_i,
    output logic [7:0]           a_rdata_o,
    output logic [7:0]           b_rdata_o
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [7:0]            rd_a;
        logic [7:0]            rd_b;
    } fes_dm_state_type;

    fes_dm_state_type s_q;
    fes_dm_state_type s_d;

    always_comb begin
        s_d      = s_q;
        s_d.rd_a = s_q.mem[a_i.addr];
        s_d.rd_b = s_q.mem[b_i.addr];
        // Port A is the core; it wins a same-address collision
        if (b_i.we) begin
            s_d.mem[b_i.addr] = b_i.wdata;
        end
        if (a_i.we) begin
            s_d.mem[a_i.addr] = a_i.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '{mem: '{default: MEM_RST}, rd_a: MEM_RST, rd_b: MEM_RST};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign a_rdata_o = s_q.rd_a;
    assign b_rdata_o = s_q.rd_b;
endmodule : fes_dmem

// ---- hdl/fes_seq.sv ----
/*
 Two-stage fetch/execute sequencer with its core special registers.
 Assumes program memory data is valid by phase four of the cycle
 whose phase one put out the address, on the same clock.
*/
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
module fes_seq
    import fes_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            resetn_i,
    input  wire logic            ce_i,
    input  wire logic [7:0]      reg_addr_i,
    input  wire logic [7:0]      reg_wdata_i,
    input  wire logic            reg_we_i,
    input  wire logic            reg_re_i,
    output logic [7:0]           reg_rdata_o,
    output logic [PC_W-1:0]      pm_addr_o,
    input  wire logic [IR_W-1:0] pm_data_i,
    output logic [1:0]           phase_o
);
    typedef struct packed {
        fes_phase_type   phase;
        logic [PC_W-1:0] pc;
        logic [PC_W-1:0] pm_addr;
        logic [IR_W-1:0] fetched;
        logic [IR_W-1:0] ir;
        logic            flush;
        logic [7:0]      w;
        logic [7:0]      status;
        logic [7:0]      ind_ptr;
        logic [4:0]      pc_hi;
        logic            run;
        logic [7:0]      opnd;
        logic            rsel_mem;
        logic [7:0]      rdata;
    } fes_state_type;

    fes_state_type   s_q;
    fes_state_type   s_d;
    fes_dm_port_type dm_core;
    fes_dm_port_type dm_bus;
    logic [7:0]      core_rdata;
    logic [7:0]      bus_rdata;
    logic            bus_pc_low_wr;

    function automatic fes_spec_type spec_of(input logic [6:0] a);
        unique case (a)
            IND_PORT_OFS[6:0]: spec_of = SP_IND_PORT;
            PC_LOW_OFS[6:0]:   spec_of = SP_PC_LOW;
            STAT_OFS[6:0]:     spec_of = SP_STAT;
            IND_PTR_OFS[6:0]:  spec_of = SP_IND_PTR;
            PC_HI_OFS[6:0]:    spec_of = SP_PC_HI;
            default:         spec_of = SP_NONE;
        endcase
    endfunction : spec_of

    function automatic logic [7:0] spec_val(input fes_spec_type sp, input fes_state_type st);
        unique case (sp)
            SP_PC_LOW:  spec_val = st.pc[7:0];
            SP_STAT:    spec_val = st.status;
            SP_IND_PTR: spec_val = st.ind_ptr;
            SP_PC_HI:   spec_val = {3'h0, st.pc_hi};
            default:   spec_val = 8'h00;
        endcase
    endfunction : spec_val

    function automatic fes_phase_type next_phase(input fes_phase_type p);
        unique case (p)
            PH_ONE:   next_phase = PH_TWO;
            PH_TWO:   next_phase = PH_THREE;
            PH_THREE: next_phase = PH_FOUR;
            PH_FOUR:  next_phase = PH_ONE;
        endcase
    endfunction : next_phase

    fes_dmem #(
        .DEPTH(256)
    ) u_dmem (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .ce_i      (ce_i),
        .a_i       (dm_core),
        .b_i       (dm_bus),
        .a_rdata_o (core_rdata),
        .b_rdata_o (bus_rdata)
    );

    fes_spec_type core_sp;
    fes_spec_type bus_sp;
    logic [7:0]   core_fa;
    logic [8:0]   sum;
    logic [7:0]   res;
    logic         to_file;

    assign core_sp    = spec_of(s_q.ir[6:0]);
    assign bus_sp     = reg_addr_i[7] ? spec_of(reg_addr_i[6:0]) : SP_NONE;
    assign bus_pc_low_wr = reg_we_i && (bus_sp == SP_PC_LOW);
    // Indirect location has no storage: the pointer picks the word
    assign core_fa    = (core_sp == SP_IND_PORT) ? s_q.ind_ptr
                                             : {s_q.status[STAT_RP0], s_q.ir[6:0]};

    always_comb begin
        s_d     = s_q;
        dm_core = '0;
        dm_bus  = '0;
        sum     = 9'h000;
        res     = 8'h00;
        to_file = 1'b0;

        // Bus side first so that a same-cycle core update wins
        dm_bus.addr = (bus_sp == SP_IND_PORT) ? s_q.ind_ptr : reg_addr_i;
        if (reg_we_i) begin
            if (reg_addr_i == CTRL_OFS) begin
                s_d.run = reg_wdata_i[CTRL_RUN];
            end else begin
                unique case (bus_sp)
                    SP_PC_LOW: begin
                        s_d.pc    = {s_q.pc_hi, reg_wdata_i};
                        s_d.flush = 1'b1;
                    end
                    SP_STAT:    s_d.status  = reg_wdata_i;
                    SP_IND_PTR: s_d.ind_ptr = reg_wdata_i;
                    SP_PC_HI:   s_d.pc_hi   = reg_wdata_i[4:0];
                    default: begin
                        dm_bus.we    = 1'b1;
                        dm_bus.wdata = reg_wdata_i;
                    end
                endcase
            end
        end
        if (reg_re_i) begin
            s_d.rsel_mem = 1'b0;
            if (reg_addr_i == CTRL_OFS) begin
                s_d.rdata = {7'h00, s_q.run};
            end else if (reg_addr_i == STATE_OFS) begin
                s_d.rdata = {5'h00, s_q.flush, s_q.phase};
            end else if (bus_sp == SP_NONE || bus_sp == SP_IND_PORT) begin
                s_d.rsel_mem = 1'b1;
            end else begin
                s_d.rdata = spec_val(bus_sp, s_q);
            end
        end

        // Phases step only while running; clk_i is the oscillator input
        if (s_q.run) begin
            s_d.phase = next_phase(s_q.phase);
            unique case (s_q.phase)
                PH_ONE: begin
                    s_d.pm_addr = s_d.pc;
                    s_d.pc      = PC_W'(s_d.pc + 1'b1);
                    s_d.ir      = s_q.flush ? IR_NOP : s_q.fetched;
                    s_d.flush   = 1'b0;
                end
                PH_TWO: begin
                    dm_core.addr = core_fa;
                end
                PH_THREE: begin
                    s_d.opnd = (core_sp == SP_NONE || core_sp == SP_IND_PORT)
                               ? core_rdata : spec_val(core_sp, s_q);
                end
                PH_FOUR: begin
                    s_d.fetched = pm_data_i;
                    unique case (s_q.ir[13:12])
                        OP_JUMP: begin
                            // The prefetched word is now stale: one lost cycle
                            s_d.pc    = {s_q.pc_hi[4:3], s_q.ir[10:0]};
                            s_d.flush = 1'b1;
                        end
                        OP_LIT: begin
                            s_d.w = s_q.ir[7:0];
                        end
                        OP_FILE: begin
                            unique case (s_q.ir[11:8])
                                FOP_MOVWF: begin
                                    res     = s_q.w;
                                    to_file = 1'b1;
                                end
                                FOP_MOVF: begin
                                    res     = s_q.opnd;
                                    to_file = s_q.ir[7];
                                    s_d.status[STAT_Z] = (res == 8'h00);
                                end
                                FOP_ADDWF: begin
                                    sum     = {1'b0, s_q.opnd} + {1'b0, s_q.w};
                                    res     = sum[7:0];
                                    to_file = s_q.ir[7];
                                    s_d.status[STAT_C] = sum[8];
                                    s_d.status[STAT_Z] = (res == 8'h00);
                                end
                                FOP_CLRF: begin
                                    to_file = 1'b1;
                                    s_d.status[STAT_Z] = 1'b1;
                                end
                                default: begin
                                end
                            endcase
                            if (!to_file && s_q.ir[11:8] != FOP_MOVWF
                                && s_q.ir[11:8] != FOP_CLRF && s_q.ir[11:8] != 4'h0) begin
                                s_d.w = res;
                            end
                        end
                        default: begin
                        end
                    endcase
                    if (to_file) begin
                        unique case (core_sp)
                            SP_PC_LOW: begin
                                s_d.pc    = {s_q.pc_hi, res};
                                s_d.flush = 1'b1;
                            end
                            SP_STAT:    s_d.status  = res;
                            SP_IND_PTR: s_d.ind_ptr = res;
                            SP_PC_HI:   s_d.pc_hi   = res[4:0];
                            default: begin
                                dm_core.we    = 1'b1;
                                dm_core.addr  = core_fa;
                                dm_core.wdata = res;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '{phase: PH_ONE, pc: '0, pm_addr: '0, fetched: IR_NOP, ir: IR_NOP,
                     flush: 1'b0, w: 8'h00, status: STAT_RST, ind_ptr: IND_PTR_RST,
                     pc_hi: PC_HI_RST, run: 1'b0, opnd: 8'h00, rsel_mem: 1'b0,
                     rdata: 8'h00};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    // Memory data is already a flop; the mux only picks the source
    assign reg_rdata_o = s_q.rsel_mem ? bus_rdata : s_q.rdata;
    assign pm_addr_o   = s_q.pm_addr;
    assign phase_o     = s_q.phase;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    phase_period_a: assert property (
        (ce_i && s_q.run && s_q.phase == PH_ONE) ##1 (ce_i && s_q.run) [*4]
        |-> s_q.phase == PH_ONE)
        else $error("phase cycle not four long");

    pc_step_a: assert property (
        ce_i && s_q.run && s_q.phase == PH_ONE && !bus_pc_low_wr
        |=> s_q.pc == PC_W'($past(s_q.pc) + 1'b1) && s_q.pm_addr == $past(s_q.pc))
        else $error("pc did not step in phase one");

    ir_load_a: assert property (
        ce_i && s_q.run && s_q.phase == PH_ONE && !s_q.flush
        |=> s_q.ir == $past(s_q.fetched))
        else $error("instruction register not loaded");

    flush_nop_a: assert property (
        ce_i && s_q.run && s_q.phase == PH_ONE && s_q.flush
        |=> s_q.ir == IR_NOP && !s_q.flush)
        else $error("prefetched word not discarded");

    jump_flush_a: assert property (
        ce_i && s_q.run && s_q.phase == PH_FOUR && s_q.ir[13:12] == OP_JUMP
        |=> s_q.flush && s_q.pc == {$past(s_q.pc_hi[4:3]), $past(s_q.ir[10:0])})
        else $error("jump did not redirect and flush");

    wr_phase_a: assert property (
        dm_core.we |-> s_q.run && s_q.phase == PH_FOUR)
        else $error("core write outside phase four");

    ptr_redir_a: assert property (
        dm_core.we && core_sp == SP_IND_PORT |-> dm_core.addr == s_q.ind_ptr)
        else $error("indirect write not redirected");

    pc_join_a: assert property (
        ce_i && bus_pc_low_wr && !s_q.run
        |=> s_q.pc == {$past(s_q.pc_hi), $past(reg_wdata_i)})
        else $error("pc high not taken from latch");

    fetch_take_a: assert property (
        ce_i && s_q.run && s_q.phase == PH_FOUR |=> s_q.fetched == $past(pm_data_i))
        else $error("fetch not latched in phase four");

    // A stopped core must not drift through its phases
    phase_hold_a: assert property (
        ce_i && !s_q.run |=> s_q.phase == $past(s_q.phase))
        else $error("phase moved while stopped");

    // Clock enable low is a true freeze, not a slower clock
    ce_freeze_a: assert property (
        !ce_i |=> s_q == $past(s_q))
        else $error("state moved with enable low");

    fetch_addr_hold_a: assert property (
        ce_i && s_q.run && s_q.phase != PH_ONE |=> s_q.pm_addr == $past(s_q.pm_addr))
        else $error("fetch address moved mid cycle");

    ir_hold_a: assert property (
        s_q.phase != PH_ONE |=> s_q.ir == $past(s_q.ir))
        else $error("instruction changed mid cycle");

    opnd_take_a: assert property (
        ce_i && s_q.run && s_q.phase == PH_THREE && core_sp == SP_NONE
        |=> s_q.opnd == $past(core_rdata))
        else $error("operand not read in phase two");

    jump_cost_a: assert property (
        (ce_i && s_q.run && s_q.phase == PH_FOUR && s_q.ir[13:12] == OP_JUMP) ##1 (ce_i && s_q.run)
        |=> s_q.ir == IR_NOP)
        else $error("jump did not cost a cycle");

    lit_load_a: assert property (
        ce_i && s_q.run && s_q.phase == PH_FOUR && s_q.ir[13:12] == OP_LIT
        |=> s_q.w == $past(s_q.ir[7:0]))
        else $error("literal not loaded");

    pc_hold_a: assert property (
        ce_i && s_q.run && s_q.phase inside {PH_TWO, PH_THREE} && !reg_we_i
        |=> s_q.pc == $past(s_q.pc))
        else $error("pc moved outside phase one");

    clr_zero_a: assert property (
        ce_i && s_q.run && s_q.phase == PH_FOUR && s_q.ir[13:12] == OP_FILE
        && s_q.ir[11:8] == FOP_CLRF && core_sp != SP_STAT
        |=> s_q.status[STAT_Z])
        else $error("clear did not set zero");

    // Software jumps through the low byte must also flush the stale word
    core_pc_load_a: assert property (
        ce_i && s_q.run && s_q.phase == PH_FOUR && to_file && core_sp == SP_PC_LOW
        |=> s_q.flush && s_q.pc[12:8] == $past(s_q.pc_hi))
        else $error("core pc write missed latch");

    ptr_read_a: assert property (
        ce_i && reg_re_i && bus_sp == SP_IND_PORT |=> s_q.rsel_mem)
        else $error("indirect read not from memory");
endmodule : fes_seq

// ---- verif/fes_pmem_model.sv ----
/*
 Program memory model that feeds instruction words to the sequencer.
 Assumes one clock and a bench that loads words through the load port.
*/
`timescale 1ns/1ns
module fes_pmem_model
    import fes_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic [PC_W-1:0] pm_addr_i,
    input  wire logic [1:0]      lat_i,
    input  wire logic            ld_we_i,
    input  wire logic [7:0]      ld_addr_i,
    input  wire logic [IR_W-1:0] ld_data_i,
    output logic [IR_W-1:0]      pm_data_o
);
    logic [IR_W-1:0] mem_q [0:255];
    logic [PC_W-1:0] last_q = '0;
    logic [1:0]      cnt_q = 2'h0;
    logic [IR_W-1:0] word;
    initial begin
        foreach (mem_q[i]) mem_q[i] = IR_NOP;
    end
    // Words above the loaded range read as no-op
    assign word = (pm_addr_i < 13'h0100) ? mem_q[pm_addr_i[7:0]] : IR_NOP;
    // Until the access time runs out the bus shows garbage, never the old word
    assign pm_data_o = (lat_i == 2'h0 || (pm_addr_i == last_q && cnt_q >= lat_i)) ? word : ~word;
    always @(posedge clk_i) begin
        if (ld_we_i) begin
            mem_q[ld_addr_i] <= ld_data_i;
        end
        if (pm_addr_i != last_q) begin
            last_q <= pm_addr_i;
            cnt_q  <= 2'h1;
        end else if (cnt_q != 2'h3) begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
endmodule : fes_pmem_model

// ---- verif/fes_seq_tb.sv ----
/*
 Self-checking bench for the fetch/execute sequencer.
 Assumes the program memory model beside it and the register map of the package.
*/
`timescale 1ns/1ns
module fes_seq_tb
    import fes_pkg::*;
;
    logic                 clk_i;
    logic                 resetn_i    = 1'b0;
    logic                 ce_i        = 1'b1;
    logic [7:0]           reg_addr_i  = 8'h00;
    logic [7:0]           reg_wdata_i = 8'h00;
    logic                 reg_we_i    = 1'b0;
    logic                 reg_re_i    = 1'b0;
    logic [7:0]           reg_rdata_o;
    logic [PC_W-1:0]      pm_addr_o;
    logic [IR_W-1:0]      pm_data_i;
    logic [1:0]           phase_o;
    logic [1:0]           lat_i       = 2'h2;
    logic                 ld_we_i     = 1'b0;
    logic [7:0]           ld_addr_i   = 8'h00;
    logic [IR_W-1:0]      ld_data_i   = '0;
    int                   err_total   = 0;
    int                   comparisons = 0;
    logic                 run_on      = 1'b0;
    logic [1:0]           last_ph     = 2'h0;
    logic [PC_W-1:0]      last_pm     = '0;
    logic [PC_W-1:0]      fetch_q[$];
    logic [IR_W-1:0]      prog [0:11] = '{14'h3055, 14'h01A0, 14'h2005, 14'h01A1, 14'h01A1, 14'h300F,
                                          14'h03A0, 14'h0180, 14'h04C0, 14'h0220, 14'h01A2, 14'h200B};
    int                   fexp [0:6]  = '{0, 1, 2, 3, 5, 6, 7};
    int                   n;

    fes_seq i_fes_seq (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .pm_addr_o(pm_addr_o), .pm_data_i(pm_data_i), .phase_o(phase_o));
    fes_pmem_model i_fes_pmem_model (.clk_i(clk_i), .pm_addr_i(pm_addr_o), .lat_i(lat_i),
        .ld_we_i(ld_we_i), .ld_addr_i(ld_addr_i), .ld_data_i(ld_data_i), .pm_data_o(pm_data_i));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("Counts: comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_we_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask : wr

    // Memory words show only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_re_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        @(negedge clk_i);
        chk(reg_rdata_o, e);
    endtask : rd

    function automatic logic [1:0] nxt(input logic [1:0] p);
        return (p == PH_ONE) ? PH_TWO : (p == PH_TWO) ? PH_THREE : (p == PH_THREE) ? PH_FOUR : PH_ONE;
    endfunction : nxt

    // Phase order; the fetch address moves only as phase one ends
    always @(negedge clk_i) begin
        if (run_on) begin
            if (phase_o !== last_ph) begin
                chk(phase_o, nxt(last_ph));
                if (phase_o === PH_TWO) begin
                    fetch_q.push_back(pm_addr_o);
                end
            end
            if (pm_addr_o !== last_pm) begin
                chk(phase_o, PH_TWO);
            end
        end
        last_ph <= phase_o;
        last_pm <= pm_addr_o;
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(negedge clk_i);
        run_on = 1'b1;
        chk(phase_o, PH_ONE);
        chk(pm_addr_o, 16'h0000);
        rd(PC_LOW_OFS, PC_LOW_RST);
        rd(STAT_OFS, STAT_RST);
        rd(IND_PTR_OFS, IND_PTR_RST);
        rd(PC_HI_OFS, 8'h00);
        rd(IND_PORT_OFS, 8'h00);
        wr(8'h40, 8'hA5);
        rd(8'h40, 8'hA5);
        wr(PC_HI_OFS, 8'hFF);
        rd(PC_HI_OFS, 8'h1F);
        wr(PC_HI_OFS, 8'h00);
        wr(IND_PTR_OFS, 8'h30);
        rd(IND_PTR_OFS, 8'h30);
        $display("test registers done");
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_i);
            ld_we_i   <= 1'b1;
            ld_addr_i <= i[7:0];
            ld_data_i <= prog[i];
        end
        @(posedge clk_i);
        ld_we_i <= 1'b0;
        wr(CTRL_OFS, 8'h01);
        repeat (20) @(posedge clk_i);
        // A stalled clock enable must only stretch the schedule
        ce_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        ce_i <= 1'b1;
        repeat (30) @(posedge clk_i);
        wr(CTRL_OFS, 8'h00);
        rd(8'h20, 8'h64);
        rd(8'h21, 8'h00);
        rd(8'h30, 8'h0F);
        rd(IND_PORT_OFS, 8'h0F);
        rd(8'h40, 8'h00);
        rd(8'h22, 8'h64);
        chk(16'(fetch_q.size() >= 7), 16'h0001);
        for (int i = 0; i < 7 && i < fetch_q.size(); i++) begin
            chk(fetch_q[i], fexp[i][15:0]);
        end
        $display("test program done");
        lat_i <= 2'h0;
        wr(PC_HI_OFS, 8'h01);
        wr(PC_LOW_OFS, 8'h10);
        rd(PC_LOW_OFS, 8'h10);
        wr(CTRL_OFS, 8'h01);
        for (n = 0; n < 12 && pm_addr_o !== 13'h0110; n++) begin
            @(negedge clk_i);
        end
        if (n == 12) begin
            err_total++;
            report_and_stop();
        end
        chk(pm_addr_o, 16'h0110);
        wr(CTRL_OFS, 8'h00);
        $display("test pc reload done");
        report_and_stop();
    end
endmodule : fes_seq_tb
